/* logic/far_pkg.sv */
package far_pkg;
  // supply section indices
  localparam int unsigned SUP_COUNT = 5;
  localparam int unsigned SUP_UV = 0;
  localparam int unsigned SUP_OV = 1;
  localparam int unsigned SUP_BUCK_OC = 2;
  localparam int unsigned SUP_OC = 3;
  localparam int unsigned SUP_SPARE = 4;
  // other-fault section indices
  localparam int unsigned OTH_COUNT = 8;
  localparam int unsigned OTH_UV = 0;
  localparam int unsigned OTH_LOW_PUMP = 1;
  localparam int unsigned OTH_HIGH_PUMP = 2;
  localparam int unsigned OTH_OTS = 3;
  localparam int unsigned OTH_SHUNT = 4;
  localparam int unsigned OTH_ROTOR = 5;
  localparam int unsigned OTH_WDOG = 6;
  localparam int unsigned OTH_NVM = 7;
  // index width and idle marker
  localparam int unsigned IDX_W = 4;
  localparam logic [IDX_W-1:0] IDX_NONE = 4'hf;
  // shunt counting modes
  typedef enum logic [1:0] {
    FAR_OC_IMMEDIATE = 2'b00,
    FAR_OC_COUNT8 = 2'b01,
    FAR_OC_COUNT16 = 2'b10
  } far_oc_mode_type;
  // functional states seen by this block
  typedef enum logic [1:0] {
    FAR_ST_STANDBY = 2'b00,
    FAR_ST_ACTIVE = 2'b01,
    FAR_ST_LOGIC_STOP = 2'b10
  } far_state_type;
  // reset values
  localparam logic [SUP_COUNT-1:0] SUP_RESET = 5'h00;
  localparam logic [OTH_COUNT-1:0] OTH_RESET = 8'h00;
endpackage

/* logic/far_arbiter.sv */
`timescale 1ns/100ps
// Overview of operation
// - arbiter picks one fault by priority
// - serviced fault blocks section until cleared
// - supply section five faults, zero highest
// - other section first-come, ties lowest index
// - both sections ORed onto fault pin
// - non-latched: action stops, status held
// - status updated on every occurrence
// - status records malfunction event immediately
// - clear-all clears; latched also need release
// - counting-mode shunt latch needs clean period
// - immediate-mode shunt latch clears once gone
// - pump undervoltage shared priority, pulls gates
// - logic supply over-v/over-c only report
// - logic undervoltage top, waits chip-enable toggle
// - logic undervoltage moves active to stop
// - buck overcurrent blanked at pump start
// - shunt overcurrent truncates, latched with brake
// - rotor lock latched, ends on driver-enable toggle or release with clear
module far_arbiter
  import far_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [far_pkg::SUP_COUNT-1:0] supply_fault_in,
  input wire logic [far_pkg::OTH_COUNT-1:0] other_fault_in,
  input wire logic malfunction_event,
  input wire logic logic_supply_good,
  input wire logic pump_starting,
  input wire logic active_state,
  input wire logic standby_state,
  input wire logic chip_enable,
  input wire logic driver_enable,
  input wire logic shunt_brake_en,
  input wire far_pkg::far_oc_mode_type shunt_mode,
  input wire logic pwm_period_end,
  input wire logic clear_all_bit,
  input wire logic latch_release_reg,
  output logic fault_out_n,
  output logic gate_pull_low,
  output logic pwm_truncate,
  output logic [far_pkg::SUP_COUNT-1:0] supply_status,
  output logic [far_pkg::OTH_COUNT-1:0] functional_fault_status,
  output logic malfunction_status,
  output logic [far_pkg::IDX_W-1:0] supply_serviced,
  output logic [far_pkg::IDX_W-1:0] other_serviced,
  output far_pkg::far_state_type func_state
);
  import far_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // qualified inputs
  logic [SUP_COUNT-1:0] sup_q;
  logic [OTH_COUNT-1:0] oth_q;
  logic shunt_latched_cfg;
  logic chip_enable_d, driver_enable_d;
  logic ce_toggled, drv_toggled;
  logic clear_p, release_p, clear_all_d, release_d;
  logic shunt_seen, shunt_clean;
  logic uv_wait;
  far_state_type next_func_state;

  // buck overcurrent only after logic good and outside pump start
  assign sup_q = {supply_fault_in[SUP_SPARE], supply_fault_in[SUP_OC],
                  supply_fault_in[SUP_BUCK_OC] & logic_supply_good & ~pump_starting,
                  supply_fault_in[SUP_OV], supply_fault_in[SUP_UV]};
  // logic undervoltage also enters other section at index zero
  assign oth_q = {other_fault_in[OTH_COUNT-1:1], other_fault_in[OTH_UV] | supply_fault_in[SUP_UV]};
  assign shunt_latched_cfg = shunt_brake_en;
  assign ce_toggled = chip_enable & ~chip_enable_d & uv_wait;
  assign drv_toggled = driver_enable & ~driver_enable_d;

  // clear strobes become one-cycle pulses on their rising edge
  assign clear_p = clear_all_bit & ~clear_all_d;
  assign release_p = latch_release_reg & ~release_d;

  ////////////////////////////////////////////////////////////////////////
  // priority pick functions
  function automatic logic [IDX_W-1:0] pick_sup(input logic [SUP_COUNT-1:0] v);
    logic [IDX_W-1:0] r;
    r = IDX_NONE;
    for (int i = SUP_COUNT - 1; i >= 0; i--)
    begin
      if (v[i])
        r = IDX_W'(i);
    end
    return r;
  endfunction

  function automatic logic [IDX_W-1:0] pick_oth(input logic [OTH_COUNT-1:0] v);
    logic [IDX_W-1:0] r;
    r = IDX_NONE;
    for (int i = OTH_COUNT - 1; i >= 0; i--)
    begin
      if (v[i])
        r = IDX_W'(i);
    end
    // pump faults share one slot: report the low index
    if (r == IDX_W'(OTH_HIGH_PUMP))
      r = IDX_W'(OTH_LOW_PUMP);
    return r;
  endfunction

  wire [IDX_W-1:0] sup_pick = pick_sup(sup_q);
  wire [IDX_W-1:0] oth_pick = pick_oth(oth_q);

  ////////////////////////////////////////////////////////////////////////
  // latched-fault hold: true while the serviced fault cannot yet end
  logic oth_is_latched;
  logic oth_cond;
  logic oth_can_end;
  logic sup_can_end;
  logic sup_cond;
  logic shunt_clearable;

  assign shunt_clearable = (shunt_mode == FAR_OC_IMMEDIATE) ? ~other_fault_in[OTH_SHUNT]
                           : (shunt_clean | standby_state);
  assign oth_is_latched = (other_serviced == IDX_W'(OTH_OTS)) | (other_serviced == IDX_W'(OTH_ROTOR))
                        | (other_serviced == IDX_W'(OTH_NVM))
                        | ((other_serviced == IDX_W'(OTH_SHUNT)) & shunt_latched_cfg);
  assign oth_cond = (other_serviced == IDX_W'(OTH_LOW_PUMP)) ? (oth_q[OTH_LOW_PUMP] | oth_q[OTH_HIGH_PUMP])
                  : (other_serviced != IDX_NONE) & oth_q[other_serviced[2:0]];
  // latched faults end only by release pulse, rotor lock also by driver toggle
  assign oth_can_end = (other_serviced == IDX_W'(OTH_UV)) ? ce_toggled
                     : (other_serviced == IDX_W'(OTH_ROTOR)) ? (release_p & clear_p | drv_toggled)
                     : (other_serviced == IDX_W'(OTH_SHUNT) & shunt_latched_cfg) ? (release_p & shunt_clearable)
                     : oth_is_latched ? release_p
                     : clear_p & ~oth_cond;
  assign sup_cond = (supply_serviced != IDX_NONE) & sup_q[supply_serviced[2:0]];
  assign sup_can_end = (supply_serviced == IDX_W'(SUP_UV)) ? ce_toggled : clear_p & ~sup_cond;

  ////////////////////////////////////////////////////////////////////////
  // section arbitration: take one fault, hold until it ends
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      supply_serviced <= IDX_NONE;
      other_serviced <= IDX_NONE;
    end
    else
    begin
      if (supply_serviced == IDX_NONE)
        supply_serviced <= sup_pick;
      else if (sup_can_end)
        supply_serviced <= IDX_NONE;
      if (other_serviced == IDX_NONE)
        other_serviced <= oth_pick;
      else if (oth_can_end)
        other_serviced <= IDX_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // edge memories and shunt clean-period tracking
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      chip_enable_d <= 1'b1; // idle level: no false rise after reset
      driver_enable_d <= 1'b1; // idle level: no false rise after reset
      clear_all_d <= 1'b0;
      release_d <= 1'b0;
      shunt_seen <= 1'b0;
      shunt_clean <= 1'b0;
    end
    else
    begin
      chip_enable_d <= chip_enable;
      driver_enable_d <= driver_enable;
      clear_all_d <= clear_all_bit;
      release_d <= latch_release_reg;
      if (pwm_period_end)
      begin
        shunt_clean <= ~shunt_seen & ~other_fault_in[OTH_SHUNT];
        shunt_seen <= 1'b0;
      end
      else if (other_fault_in[OTH_SHUNT])
      begin
        shunt_seen <= 1'b1;
        shunt_clean <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // action decode for the serviced faults
  wire oth_active = other_serviced != IDX_NONE;
  wire oth_pulls = oth_active & (oth_is_latched | oth_cond) & (other_serviced != IDX_W'(OTH_WDOG));
  // logic stop pulls the gates even when both sections were already busy
  wire next_gate_pull = oth_pulls | (supply_serviced == IDX_W'(SUP_UV))
                      | (func_state == FAR_ST_LOGIC_STOP);
  wire next_fault_n = ~((supply_serviced != IDX_NONE) | oth_active);
  wire next_trunc = other_fault_in[OTH_SHUNT] & (other_serviced == IDX_W'(OTH_SHUNT));

  // functional state follows logic undervoltage
  always_comb
  begin
    next_func_state = func_state;
    unique case (func_state)
      FAR_ST_STANDBY:
        if (supply_fault_in[SUP_UV])
          next_func_state = FAR_ST_LOGIC_STOP;
        else if (active_state)
          next_func_state = FAR_ST_ACTIVE;
      FAR_ST_ACTIVE:
        if (supply_fault_in[SUP_UV])
          next_func_state = FAR_ST_LOGIC_STOP;
        else if (!active_state)
          next_func_state = FAR_ST_STANDBY;
      FAR_ST_LOGIC_STOP:
        if (ce_toggled)
          next_func_state = FAR_ST_STANDBY;
      default:
        next_func_state = FAR_ST_STANDBY;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs and status; set wins over clear
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      fault_out_n <= 1'b1;
      gate_pull_low <= 1'b0;
      pwm_truncate <= 1'b0;
      supply_status <= SUP_RESET;
      functional_fault_status <= OTH_RESET;
      malfunction_status <= 1'b0;
      func_state <= FAR_ST_STANDBY;
      uv_wait <= 1'b0;
    end
    else
    begin
      fault_out_n <= next_fault_n;
      gate_pull_low <= next_gate_pull;
      pwm_truncate <= next_trunc;
      supply_status <= (clear_p ? SUP_RESET : supply_status) | sup_q;
      functional_fault_status <= (clear_p ? OTH_RESET : functional_fault_status) | oth_q;
      malfunction_status <= (~clear_p & malfunction_status) | malfunction_event;
      func_state <= next_func_state;
      uv_wait <= supply_fault_in[SUP_UV] | (uv_wait & ~(chip_enable & ~chip_enable_d));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_pick_low;
    @(posedge clk) disable iff (reset)
      (other_serviced == IDX_NONE && oth_q[0]) |=> other_serviced == IDX_W'(0);
  endproperty
  a_pick_low: assert property (p_pick_low) else $error("index zero not taken");

  property p_hold;
    @(posedge clk) disable iff (reset)
      (other_serviced != IDX_NONE && !oth_can_end) |=> $stable(other_serviced);
  endproperty
  a_hold: assert property (p_hold) else $error("section changed while busy");

  property p_sup_prio;
    @(posedge clk) disable iff (reset)
      (supply_serviced == IDX_NONE && sup_q[0] && sup_q[3]) |=> supply_serviced == IDX_W'(0);
  endproperty
  a_sup_prio: assert property (p_sup_prio) else $error("supply priority wrong");

  property p_pin;
    @(posedge clk) disable iff (reset)
      (supply_serviced != IDX_NONE || other_serviced != IDX_NONE) |=> !fault_out_n;
  endproperty
  a_pin: assert property (p_pin) else $error("fault pin not asserted");

  property p_status;
    @(posedge clk) disable iff (reset)
      supply_fault_in[SUP_OV] |=> supply_status[SUP_OV];
  endproperty
  a_status: assert property (p_status) else $error("status missed event");

  property p_malf;
    @(posedge clk) disable iff (reset)
      malfunction_event |=> malfunction_status;
  endproperty
  a_malf: assert property (p_malf) else $error("malfunction not recorded");

  property p_latched_stays;
    @(posedge clk) disable iff (reset)
      (other_serviced == IDX_W'(OTH_OTS) && !release_p) |=> other_serviced == IDX_W'(OTH_OTS);
  endproperty
  a_latched_stays: assert property (p_latched_stays) else $error("latched fault ended");

  property p_uv_stop;
    @(posedge clk) disable iff (reset)
      (func_state == FAR_ST_ACTIVE && supply_fault_in[SUP_UV]) |=> func_state == FAR_ST_LOGIC_STOP ##1 gate_pull_low;
  endproperty
  a_uv_stop: assert property (p_uv_stop) else $error("undervoltage not handled");

  property p_ov_no_pull;
    @(posedge clk) disable iff (reset)
      (supply_serviced == IDX_W'(SUP_OV) && other_serviced == IDX_NONE && func_state != FAR_ST_LOGIC_STOP)
      |=> !gate_pull_low;
  endproperty
  a_ov_no_pull: assert property (p_ov_no_pull) else $error("report-only fault acted");
endmodule // far_arbiter

/* bench/far_mcu_model.sv */
`timescale 1ns/100ps
module far_mcu_model
(
  input wire logic clk,
  input wire logic reset,
  input wire logic want_clear,
  input wire logic want_release,
  output logic clear_all_bit,
  output logic latch_release_reg
);
  ////////////////////////////////////////////////////////////
  // controller writes turn into one-cycle clear pulses, never a held level
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      clear_all_bit <= 1'b0;
      latch_release_reg <= 1'b0;
    end
    else
    begin
      clear_all_bit <= want_clear & ~clear_all_bit;
      latch_release_reg <= want_release & ~latch_release_reg;
    end
  end
endmodule // far_mcu_model

/* bench/tb_fault_arbitration_reporting.sv */
`timescale 1ns/100ps
module tb_fault_arbitration_reporting;
  import far_pkg::*;
  logic clk, reset, malfunction_event, logic_supply_good, pump_starting, active_state;
  logic standby_state, chip_enable, driver_enable, shunt_brake_en, pwm_period_end;
  logic want_clear, want_release, clear_all_bit, latch_release_reg;
  logic fault_out_n, gate_pull_low, pwm_truncate, malfunction_status;
  logic [4:0] supply_fault_in, supply_status;
  logic [7:0] other_fault_in, functional_fault_status;
  logic [3:0] supply_serviced, other_serviced;
  far_oc_mode_type shunt_mode;
  far_state_type func_state;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////
  // device under test and controller model
  far_arbiter uut (.clk(clk), .reset(reset), .supply_fault_in(supply_fault_in),
    .other_fault_in(other_fault_in), .malfunction_event(malfunction_event),
    .logic_supply_good(logic_supply_good), .pump_starting(pump_starting), .active_state(active_state),
    .standby_state(standby_state), .chip_enable(chip_enable), .driver_enable(driver_enable),
    .shunt_brake_en(shunt_brake_en), .shunt_mode(shunt_mode), .pwm_period_end(pwm_period_end),
    .clear_all_bit(clear_all_bit), .latch_release_reg(latch_release_reg), .fault_out_n(fault_out_n),
    .gate_pull_low(gate_pull_low), .pwm_truncate(pwm_truncate), .supply_status(supply_status),
    .functional_fault_status(functional_fault_status), .malfunction_status(malfunction_status),
    .supply_serviced(supply_serviced), .other_serviced(other_serviced), .func_state(func_state));
  far_mcu_model mcu (.clk(clk), .reset(reset), .want_clear(want_clear), .want_release(want_release),
    .clear_all_bit(clear_all_bit), .latch_release_reg(latch_release_reg));
  ////////////////////////////////////////////////////////////
  // shared tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one controller write of the clear bit, optionally with the latch release
  task automatic clear_faults(input logic rel);
    @(posedge clk);
    want_clear <= 1'b1;
    want_release <= rel;
    @(posedge clk);
    want_clear <= 1'b0;
    want_release <= 1'b0;
    step(4);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      mismatches++;
      test_done;
    end
  end
  ////////////////////////////////////////////////////////////
  // test sequence
  initial
  begin
    reset = 1'b1;
    {supply_fault_in, other_fault_in, malfunction_event, pump_starting, standby_state} = '0;
    {shunt_brake_en, pwm_period_end, want_clear, want_release} = '0;
    {logic_supply_good, active_state, chip_enable, driver_enable} = 4'hf;
    shunt_mode = FAR_OC_IMMEDIATE;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    step(1);
    check("reset pin", 8'h01, fault_out_n);
    check("reset other idx", 8'h0f, other_serviced);
    check("reset supply idx", 8'h0f, supply_serviced);
    $display("test reset done");
    // latched shutdown, then a later fault while the section is busy
    @(posedge clk) other_fault_in <= 8'h08;
    step(1);
    check("other idx", 8'h03, other_serviced);
    check("other status", 8'h08, functional_fault_status);
    step(1);
    check("pin", 8'h00, fault_out_n);
    check("gate", 8'h01, gate_pull_low);
    @(posedge clk) other_fault_in <= 8'h18;
    step(2);
    check("busy idx", 8'h03, other_serviced);
    check("late status", 8'h18, functional_fault_status);
    @(posedge clk) other_fault_in <= 8'h00;
    clear_faults(1'b0);
    check("latched held", 8'h03, other_serviced);
    clear_faults(1'b1);
    check("latched free", 8'h0f, other_serviced);
    check("pin free", 8'h01, fault_out_n);
    $display("test latched done");
    // simultaneous supply reports
    @(posedge clk) supply_fault_in <= 5'h0a;
    step(1);
    check("supply idx", 8'h01, supply_serviced);
    step(1);
    check("supply pin", 8'h00, fault_out_n);
    check("supply gate", 8'h00, gate_pull_low);
    check("supply status", 8'h0a, supply_status);
    @(posedge clk) supply_fault_in <= 5'h00;
    clear_faults(1'b0);
    check("supply free", 8'h0f, supply_serviced);
    check("supply cleared", 8'h00, supply_status);
    $display("test supply done");
    // both pump undervoltages at once share one priority
    @(posedge clk) other_fault_in <= 8'h06;
    step(1);
    check("pump idx", 8'h01, other_serviced);
    step(1);
    check("pump gate", 8'h01, gate_pull_low);
    @(posedge clk) other_fault_in <= 8'h00;
    step(2);
    check("pump gate off", 8'h00, gate_pull_low);
    check("pump pin held", 8'h00, fault_out_n);
    check("pump status held", 8'h06, functional_fault_status);
    clear_faults(1'b0);
    check("pump free", 8'h0f, other_serviced);
    $display("test pump done");
    // logic undervoltage with a malfunction event in the same cycle
    @(posedge clk);
    supply_fault_in <= 5'h01;
    other_fault_in <= 8'h01;
    malfunction_event <= 1'b1;
    @(posedge clk) malfunction_event <= 1'b0;
    #1;
    check("uv supply idx", 8'h00, supply_serviced);
    check("uv other idx", 8'h00, other_serviced);
    check("malfunction", 8'h01, malfunction_status);
    step(2);
    check("uv gate", 8'h01, gate_pull_low);
    check("uv state", FAR_ST_LOGIC_STOP, func_state);
    @(posedge clk);
    supply_fault_in <= 5'h00;
    other_fault_in <= 8'h00;
    clear_faults(1'b1);
    check("uv holds", 8'h00, supply_serviced);
    @(posedge clk) chip_enable <= 1'b0;
    step(2);
    @(posedge clk) chip_enable <= 1'b1;
    step(4);
    check("uv restart", 8'h0f, supply_serviced);
    check("uv pin", 8'h01, fault_out_n);
    $display("test undervoltage done");
    // buck overcurrent blanked while the pumps start
    @(posedge clk);
    pump_starting <= 1'b1;
    supply_fault_in <= 5'h04;
    step(2);
    check("buck blanked", 8'h0f, supply_serviced);
    @(posedge clk) pump_starting <= 1'b0;
    step(1);
    check("buck idx", 8'h02, supply_serviced);
    @(posedge clk) supply_fault_in <= 5'h00;
    clear_faults(1'b0);
    check("buck free", 8'h0f, supply_serviced);
    $display("test buck done");
    // latched shunt overcurrent: counting mode needs a clean period
    @(posedge clk);
    shunt_brake_en <= 1'b1;
    shunt_mode <= FAR_OC_COUNT8;
    other_fault_in <= 8'h10;
    step(2);
    check("shunt idx", 8'h04, other_serviced);
    check("shunt trunc", 8'h01, pwm_truncate);
    check("shunt gate", 8'h01, gate_pull_low);
    @(posedge clk) other_fault_in <= 8'h00;
    clear_faults(1'b1);
    check("shunt held", 8'h04, other_serviced);
    check("trunc off", 8'h00, pwm_truncate);
    repeat (2)
    begin
      @(posedge clk) pwm_period_end <= 1'b1;
      @(posedge clk) pwm_period_end <= 1'b0;
    end
    clear_faults(1'b1);
    check("shunt count free", 8'h0f, other_serviced);
    // immediate mode: release only counts once the overcurrent is gone
    @(posedge clk);
    shunt_mode <= FAR_OC_IMMEDIATE;
    other_fault_in <= 8'h10;
    step(2);
    clear_faults(1'b1);
    check("shunt present held", 8'h04, other_serviced);
    @(posedge clk) other_fault_in <= 8'h00;
    clear_faults(1'b1);
    check("shunt immediate free", 8'h0f, other_serviced);
    $display("test shunt done");
    // rotor lock stays latched until the driver enable is toggled
    @(posedge clk) other_fault_in <= 8'h20;
    step(2);
    check("rotor idx", 8'h05, other_serviced);
    check("rotor gate", 8'h01, gate_pull_low);
    @(posedge clk) other_fault_in <= 8'h00;
    clear_faults(1'b0);
    check("rotor held", 8'h05, other_serviced);
    @(posedge clk) driver_enable <= 1'b0;
    step(2);
    @(posedge clk) driver_enable <= 1'b1;
    step(4);
    check("rotor free", 8'h0f, other_serviced);
    check("rotor pin", 8'h01, fault_out_n);
    $display("test rotor done");
    test_done;
  end
endmodule // tb_fault_arbitration_reporting
